// [src/link_mode_pkg.sv]
/*
  Constants for the serial link mode controller: register offsets, field
  positions, reset values, mode codes and frequency thresholds.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package link_mode_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] freq_off = 8'h08;
  localparam logic [7:0] rx_caps_off = 8'h0c;
  // Control register fields
  localparam int auto_dis_bit = 0;
  localparam int force_lsb = 1;
  localparam int hs_ctrl_bit = 3;
  localparam int pll_rst_bit = 5;
  localparam int prot_en_bit = 6;
  localparam logic [31:0] ctrl_reset = 32'h0000_0020;
  // Forced mode codes, 2 bits
  localparam logic [1:0] force_single = 2'h0;
  localparam logic [1:0] force_dual = 2'h1;
  localparam logic [1:0] force_repl = 2'h2;
  localparam logic [1:0] force_second = 2'h3;
  // Frequency thresholds in MHz
  localparam int single_max_mhz = 96;
  localparam int legacy_max_mhz = 85;
  localparam int dual_max_mhz = 170;
  localparam int repl_max_mhz = 85;
  localparam int dual_min_mhz = 96;
  // Measurement window: 1 us at 100 MHz gives pixel count in MHz
  localparam int clk_mhz = 100;
  localparam int window_ns = 1000;
  localparam int window_cycles = window_ns * clk_mhz / 1000;
  // Largest frequency change that does not yet count as a change, MHz
  localparam int freq_change_mhz = 2;
  localparam int pll_rst_cycles = 4;
  localparam int fifo_depth = 16;
  typedef enum logic [2:0] {
    mode_off, mode_single, mode_dual, mode_repl, mode_second
  } link_mode_t;
endpackage

// [src/link_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module link_fifo #(
  parameter int width = 24,
  parameter int depth = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Fill side
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw:0] wr_ptr;
  logic [aw:0] rd_ptr;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {aw{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[aw-1:0]];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  // Storage carries no reset
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr[aw-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [src/link_mode_ctrl.sv]
/*
  Serial link mode controller: picks single, dual, replicate or
  secondary-only mode, steers pixels onto two transmit links, measures
  the pixel rate and holds the PLL-reset-on-frequency-change enable.
  Assumes pixel inputs synchronous to aclk and receiver presence and
  capability levels supplied by the link physical layers.
*/
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module link_mode_ctrl #(
  parameter int pix_width = 24
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pixel input stream
  input wire logic [pix_width-1:0] pix_data,
  input wire logic pix_valid,
  output logic pix_ready,
  // Downstream receiver probe results
  input wire logic rx0_present,
  input wire logic rx0_dual_cap,
  input wire logic rx0_legacy,
  input wire logic rx0_hs_ctrl_cap,
  input wire logic rx1_present,
  // Transmit link 0
  output logic [pix_width-1:0] tx0_data,
  output logic tx0_valid,
  input wire logic tx0_ready,
  // Transmit link 1
  output logic [pix_width-1:0] tx1_data,
  output logic tx1_valid,
  input wire logic tx1_ready,
  // Link controls
  output logic tx1_phy_en,
  output logic back_chan1_en,
  output logic hs_ctrl_en,
  output logic prot_single_session,
  output logic prot_core2_en,
  output logic pll_reset,
  output logic rate_fault
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl;
  link_mode_pkg::link_mode_t mode;
  link_mode_pkg::link_mode_t next_mode;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic auto_dis;
  logic [1:0] force_code;
  logic [7:0] freq_mhz;
  logic [7:0] pix_count;
  logic [7:0] win_cnt;
  logic [2:0] pll_cnt;
  logic phase;
  logic [pix_width-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic [pix_width-1:0] n_data;
  logic [8:0] freq_diff;
  logic take;
  logic slot0_free;
  logic slot1_free;

  assign auto_dis = ctrl[link_mode_pkg::auto_dis_bit];
  assign force_code = ctrl[link_mode_pkg::force_lsb +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign wr_hit = aw_addr == link_mode_pkg::ctrl_off;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2; // Unmapped writes get SLVERR
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register; forced mode stays until software rewrites it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= link_mode_pkg::ctrl_reset;
    end else if (ce && wr_fire && wr_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          ctrl[b*8 +: 8] <= w_data[b*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel, one word, answer two cycles after address valid
  always_comb begin
    unique case (s_axi_araddr)
      link_mode_pkg::ctrl_off: rd_word = ctrl;
      link_mode_pkg::status_off: rd_word = {28'h0000000, pll_reset, mode};
      link_mode_pkg::freq_off: rd_word = {24'h000000, freq_mhz};
      link_mode_pkg::rx_caps_off:
        rd_word = {27'h0000000, rx1_present, rx0_hs_ctrl_cap, rx0_legacy,
                   rx0_dual_cap, rx0_present};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0)
                       ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel rate: input pixels counted over a 1 us window give MHz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt <= 8'h00;
      pix_count <= 8'h00;
      freq_mhz <= 8'h00;
    end else if (ce) begin
      if (win_cnt == 8'(link_mode_pkg::window_cycles - 1)) begin
        win_cnt <= 8'h00;
        pix_count <= 8'h00;
        freq_mhz <= pix_count;
      end else begin
        win_cnt <= win_cnt + 8'h01;
        if (pix_valid && pix_ready) begin
          pix_count <= pix_count + 8'h01;
        end
      end
    end
  end

  // Rate step seen by the PLL logic at each window end
  assign freq_diff = (pix_count > freq_mhz) ? {1'b0, pix_count - freq_mhz}
                                            : {1'b0, freq_mhz - pix_count};

  // PLL reset pulse of pll_rst_cycles cycles on a rate change, only while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_cnt <= 3'h0;
      pll_reset <= 1'b0;
    end else if (ce) begin
      if (!ctrl[link_mode_pkg::pll_rst_bit]) begin
        pll_cnt <= 3'h0;
        pll_reset <= 1'b0;
      end else if (win_cnt == 8'(link_mode_pkg::window_cycles - 1) &&
                   freq_diff > 9'(link_mode_pkg::freq_change_mhz)) begin
        pll_cnt <= 3'(link_mode_pkg::pll_rst_cycles);
        pll_reset <= 1'b1;
      end else if (pll_cnt != 3'h0) begin
        pll_cnt <= pll_cnt - 3'h1;
        pll_reset <= pll_cnt != 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode choice from forcing, receiver probes and pixel rate
  always_comb begin
    next_mode = link_mode_pkg::mode_off;
    if (auto_dis) begin
      unique case (force_code)
        link_mode_pkg::force_single: next_mode = link_mode_pkg::mode_single;
        link_mode_pkg::force_dual: next_mode = link_mode_pkg::mode_dual;
        link_mode_pkg::force_repl: next_mode = link_mode_pkg::mode_repl;
        link_mode_pkg::force_second: next_mode = link_mode_pkg::mode_second;
      endcase
    end else if (rx0_present && rx1_present && !rx0_dual_cap) begin
      next_mode = link_mode_pkg::mode_repl;
    end else if (rx0_present && rx0_dual_cap &&
                 freq_mhz >= 8'(link_mode_pkg::dual_min_mhz)) begin
      next_mode = link_mode_pkg::mode_dual;
    end else if (rx0_present) begin
      next_mode = link_mode_pkg::mode_single;
    end else if (rx1_present) begin
      next_mode = link_mode_pkg::mode_second;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= link_mode_pkg::mode_off;
    end else if (ce) begin
      mode <= next_mode;
    end
  end

  // Rate above what the mode or receiver allows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_fault <= 1'b0;
    end else if (ce) begin
      unique case (mode)
        link_mode_pkg::mode_single, link_mode_pkg::mode_second:
          rate_fault <= freq_mhz > 8'(rx0_legacy ? link_mode_pkg::legacy_max_mhz
                                                 : link_mode_pkg::single_max_mhz);
        link_mode_pkg::mode_dual:
          rate_fault <= freq_mhz > 8'(link_mode_pkg::dual_max_mhz);
        link_mode_pkg::mode_repl:
          rate_fault <= freq_mhz > 8'(link_mode_pkg::repl_max_mhz);
        link_mode_pkg::mode_off: rate_fault <= 1'b0;
      endcase
    end
  end

  // Link side controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx1_phy_en <= 1'b0;
      back_chan1_en <= 1'b0;
      hs_ctrl_en <= 1'b0;
      prot_single_session <= 1'b0;
      prot_core2_en <= 1'b0;
    end else if (ce) begin
      tx1_phy_en <= mode != link_mode_pkg::mode_single &&
                    mode != link_mode_pkg::mode_off;
      back_chan1_en <= mode != link_mode_pkg::mode_single &&
                       mode != link_mode_pkg::mode_off;
      hs_ctrl_en <= ctrl[link_mode_pkg::hs_ctrl_bit] && rx0_hs_ctrl_cap &&
                    !(auto_dis && force_code == link_mode_pkg::force_single) &&
                    (mode == link_mode_pkg::mode_single ||
                     mode == link_mode_pkg::mode_dual);
      prot_single_session <= ctrl[link_mode_pkg::prot_en_bit] &&
                             mode == link_mode_pkg::mode_dual;
      prot_core2_en <= ctrl[link_mode_pkg::prot_en_bit] &&
                       mode == link_mode_pkg::mode_repl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel FIFO in front of the link steering
  link_fifo #(
    .width(pix_width),
    .depth(link_mode_pkg::fifo_depth)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_data(pix_data),
    .in_valid(pix_valid && pix_ready),
    .in_ready(f_ready),
    .out_data(n_data),
    .out_valid(f_valid),
    .out_ready(take)
  );
  assign f_data = n_data;

  // FIFO ready feeds back to the source through a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_ready <= 1'b0;
    end else if (ce) begin
      pix_ready <= f_ready && !(pix_valid && pix_ready);
    end
  end

  // A pixel leaves when its target link slot is free
  assign slot0_free = !tx0_valid || tx0_ready;
  assign slot1_free = !tx1_valid || tx1_ready;
  always_comb begin
    take = 1'b0;
    unique case (mode)
      link_mode_pkg::mode_single: take = f_valid && slot0_free;
      link_mode_pkg::mode_second: take = f_valid && slot1_free;
      link_mode_pkg::mode_dual: take = f_valid && (phase ? slot1_free : slot0_free);
      link_mode_pkg::mode_repl: take = f_valid && slot0_free && slot1_free;
      link_mode_pkg::mode_off: take = 1'b0;
    endcase
  end

  // Link 0 output register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx0_valid <= 1'b0;
      tx0_data <= '0;
    end else if (ce) begin
      if (take && (mode == link_mode_pkg::mode_single ||
                   mode == link_mode_pkg::mode_repl ||
                   (mode == link_mode_pkg::mode_dual && !phase))) begin
        tx0_valid <= 1'b1;
        tx0_data <= f_data;
      end else if (tx0_ready) begin
        tx0_valid <= 1'b0;
      end
    end
  end

  // Link 1 output register; odd pixels in dual mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx1_valid <= 1'b0;
      tx1_data <= '0;
      phase <= 1'b0;
    end else if (ce) begin
      if (mode != link_mode_pkg::mode_dual) begin
        phase <= 1'b0;
      end else if (take) begin
        phase <= !phase;
      end
      if (take && (mode == link_mode_pkg::mode_second ||
                   mode == link_mode_pkg::mode_repl ||
                   (mode == link_mode_pkg::mode_dual && phase))) begin
        tx1_valid <= 1'b1;
        tx1_data <= f_data;
      end else if (tx1_ready) begin
        tx1_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/link_mode_props.sv]
/*
  Checker for the link mode controller, bound to its top ports.
  Assumes software writes the control register with wstrb[0] set.
*/
`timescale 1ns/1ps
`default_nettype none
module link_mode_props #(
  parameter int pix_width = 24
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Links and controls
  input wire logic [pix_width-1:0] tx0_data,
  input wire logic tx0_valid,
  input wire logic tx0_ready,
  input wire logic tx1_valid,
  input wire logic tx1_ready,
  input wire logic tx1_phy_en,
  input wire logic back_chan1_en,
  input wire logic hs_ctrl_en,
  input wire logic prot_single_session,
  input wire logic prot_core2_en,
  input wire logic pll_reset
);
  logic [7:0] aw_q;
  logic [7:0] wd_q;
  logic ws_q;
  logic [7:0] ctrl;
  logic [3:0] settle;
  logic forced;
  logic [1:0] fm;
  //////////////////////////////////////////////////////////////////////////////
  // Shadow of the control byte; only checked once the effect has had time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= link_mode_pkg::ctrl_reset[7:0];
      settle <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && ws_q &&
                 aw_q == link_mode_pkg::ctrl_off) begin
      ctrl <= wd_q;
      settle <= 4'h0;
    end else if (settle != 4'hf) begin
      settle <= settle + 4'h1;
    end
  end
  // Capture address and data in whichever order they are taken
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) begin
      wd_q <= s_axi_wdata[7:0];
      ws_q <= s_axi_wstrb[0];
    end
  end
  assign forced = settle == 4'hf && ctrl[link_mode_pkg::auto_dis_bit];
  assign fm = ctrl[2:1];
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_single_phy_off: assert property (forced && fm == link_mode_pkg::force_single |->
    !tx1_phy_en && !back_chan1_en) else $error("secondary phy on in forced single");
  a_single_one_link: assert property (forced && fm == link_mode_pkg::force_single |->
    !tx1_valid) else $error("secondary link carries pixels in single mode");
  a_dual_one_session: assert property (forced && fm == link_mode_pkg::force_dual && ctrl[6]
    |-> prot_single_session && !prot_core2_en) else $error("dual mode protection wrong");
  a_repl_core_two: assert property (forced && fm == link_mode_pkg::force_repl && ctrl[6]
    |-> prot_core2_en && !prot_single_session) else $error("replicate second core off");
  a_prot_off_idle: assert property (settle == 4'hf && !ctrl[6] |->
    !prot_single_session && !prot_core2_en) else $error("protection active while disabled");
  a_pll_gate_off: assert property (settle == 4'hf && !ctrl[5] |-> !pll_reset)
    else $error("pll reset while disabled");
  a_pll_pulse_len: assert property ($rose(pll_reset) |-> pll_reset[*4] ##1 !pll_reset)
    else $error("pll reset pulse length wrong");
  a_hs_needs_enable: assert property (settle == 4'hf && hs_ctrl_en |-> ctrl[3])
    else $error("control traffic enabled without request");
  a_tx0_held_stall: assert property (tx0_valid && !tx0_ready |=> tx0_valid &&
    $stable(tx0_data)) else $error("link pixel dropped under stall");
  c_pll_pulse: cover property ($rose(pll_reset));
  c_dual_session: cover property (prot_single_session);
  c_repl_core: cover property (prot_core2_en);
  c_tx1_move: cover property (tx1_valid && tx1_ready);
endmodule
bind link_mode_ctrl link_mode_props #(.pix_width(pix_width)) props_u (.*);
`default_nettype wire

// [tb/link_rx_model.sv]
/*
  Downstream receiver model: accepts pixels with random stalls.
  Assumes one clock; hold freezes the receiver to back up the block.
*/
`timescale 1ns/1ps
`default_nettype none
module link_rx_model #(
  parameter int width = 24
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link from the block
  input wire logic [width-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic hold,
  output logic tx_ready,
  // Received words
  output logic rx_fire,
  output logic [width-1:0] rx_word
);
  // A real receiver is not always free, so ready drops at random
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_ready <= 1'b0;
    else tx_ready <= !hold && ($urandom_range(3) != 0);
  end
  assign rx_fire = tx_valid && tx_ready;
  assign rx_word = tx_data;
endmodule
`default_nettype wire

// [tb/serial_link_mode_controller_bench.sv]
/*
  Self-checking bench for the link mode controller with two receivers.
  Assumes the register map and latencies of the package and hand-over.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_link_mode_controller_bench;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] pix_data, tx0_data, tx1_data, word0, word1;
  logic pix_valid, pix_ready, rx0_present, rx0_dual_cap, rx0_legacy, rx0_hs_ctrl_cap;
  logic rx1_present, tx0_valid, tx0_ready, tx1_valid, tx1_ready, tx1_phy_en, back_chan1_en;
  logic hs_ctrl_en, prot_single_session, prot_core2_en, pll_reset, rate_fault;
  logic fire0, fire1, hold0;
  logic [33:0] exp_r[$], exp_w[$];
  logic [23:0] exp0[$], exp1[$];
  logic [5:0] auto_tab[4] = '{6'h2b, 6'h0c, 6'h31, 6'h21};
  int bad_count = 0;
  int num_checks = 0;
  int unsigned seed_v;
  link_mode_ctrl dut_u (.*);
  link_rx_model rx0_u (.aclk(aclk), .aresetn(aresetn), .tx_data(tx0_data),
    .tx_valid(tx0_valid), .hold(hold0), .tx_ready(tx0_ready), .rx_fire(fire0), .rx_word(word0));
  link_rx_model rx1_u (.aclk(aclk), .aresetn(aresetn), .tx_data(tx1_data),
    .tx_valid(tx1_valid), .hold(1'b0), .tx_ready(tx1_ready), .rx_fire(fire1), .rx_word(word1));
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic check_word(input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic check_pix(input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Bus writes: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_w.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    give_up(n, 200);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    s_axi_rready <= 1'b0;
    give_up(n, 200);
    @(posedge aclk);
  endtask
  // Pixels noted per link by mode: 1 single, 2 dual, 3 replicate, 4 secondary
  task automatic send(input int cnt, input int m);
    logic [23:0] p;
    int n;
    logic alt;
    alt = 1'b0;
    for (int k = 0; k < cnt; k++) begin
      p = 24'($urandom);
      n = 0;
      pix_data <= p;
      pix_valid <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
      end while (!pix_ready && n < 400);
      give_up(n, 400);
      if (m == 1 || m == 3 || (m == 2 && !alt)) exp0.push_back(p);
      if (m == 4 || m == 3 || (m == 2 && alt)) exp1.push_back(p);
      alt = !alt;
    end
    pix_valid <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((exp0.size() != 0 || exp1.size() != 0) && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    give_up(n, 2000);
    repeat (250) @(posedge aclk);
  endtask
  task automatic rand_rx();
    {rx0_present, rx0_dual_cap, rx0_legacy, rx0_hs_ctrl_cap, rx1_present} <= 5'($urandom);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watcher: every result takes the oldest note of its kind
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check_word(exp_w.size() ? exp_w.pop_front() : 34'hx,
      {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) check_word(exp_r.size() ? exp_r.pop_front() : 34'hx,
      {s_axi_rresp, s_axi_rdata});
    if (fire0) check_pix(exp0.size() ? exp0.pop_front() : 24'hx, word0);
    if (fire1) check_pix(exp1.size() ? exp1.pop_front() : 24'hx, word1);
  end
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {pix_valid, hold0, rx0_present, rx0_dual_cap, rx0_legacy, rx0_hs_ctrl_cap} = '0;
    {rx1_present, s_axi_awaddr, s_axi_araddr, s_axi_wdata, pix_data} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    seed_v = $urandom(32'hd4ea);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(link_mode_pkg::ctrl_off, 32'h20, 2'h0);
    rd(8'h10, 32'h0, 2'h2);
    rd(8'h02, 32'h0, 2'h2);
    wr(8'h14, 32'hff, 2'h2);
    // Every forced mode, receivers changing underneath
    for (int k = 0; k < 4; k++) begin
      rand_rx();
      wr(link_mode_pkg::ctrl_off, 32'h69 | 32'(k * 2), 2'h0);
      repeat (20) @(posedge aclk);
      fork
        begin
          if (k == 0) begin
            hold0 <= 1'b1;
            repeat (100) @(posedge aclk);
            check_pix(24'h0, {23'h0, pix_ready});
            hold0 <= 1'b0;
          end
        end
        send(40, k + 1);
      join
      rand_rx();
      drain();
      rd(link_mode_pkg::status_off, 32'(k + 1), 2'h0);
    end
    // Auto detection by attached receivers at low rate
    for (int j = 0; j < 4; j++) begin
      {rx0_present, rx0_dual_cap, rx1_present} <= auto_tab[j][5:3];
      wr(link_mode_pkg::ctrl_off, 32'h20, 2'h0);
      repeat (250) @(posedge aclk);
      rd(link_mode_pkg::status_off, 32'(auto_tab[j][2:0]), 2'h0);
      rd(link_mode_pkg::freq_off, 32'h0, 2'h0);
      rd(link_mode_pkg::rx_caps_off, {27'h0, rx1_present, rx0_hs_ctrl_cap, rx0_legacy,
        rx0_dual_cap, rx0_present}, 2'h0);
    end
    // Host ends setup by clearing the PLL reset enable
    wr(link_mode_pkg::ctrl_off, 32'h0, 2'h0);
    rd(link_mode_pkg::ctrl_off, 32'h0, 2'h0);
    send(20, 1);
    check_pix(24'h0, {23'h0, rate_fault});
    drain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
